// ===== tio_pkg.sv
// package for the traction io function configuration block
package tio_pkg;
  // pin seven function codes
  localparam logic       PIN7_SPEED_LIMIT = 1'h0;
  localparam logic       PIN7_HANDBRAKE   = 1'h1;
  // steer trigger codes
  localparam logic [1:0] STEER_FOOT       = 2'h0;
  localparam logic [1:0] STEER_DIR        = 2'h1;
  localparam logic [1:0] STEER_SEAT       = 2'h2;
  localparam logic [1:0] STEER_FOOT_SPEED = 2'h3;
  // truck type codes
  localparam logic [1:0] TRUCK_RIDE       = 2'h0;
  localparam logic [1:0] TRUCK_WALK       = 2'h1;
  localparam logic [1:0] TRUCK_WALK_OPEN  = 2'h2;
  // tiller function codes
  localparam logic [1:0] TILL_HOLD        = 2'h0;
  localparam logic [1:0] TILL_STOP_BRAKE  = 2'h1;
  localparam logic [1:0] TILL_OPEN_BRAKE  = 2'h2;
  // error filter codes
  localparam logic [1:0] ERR_HARD         = 2'h0;
  localparam logic [1:0] ERR_MAIN         = 2'h1;
  localparam logic [1:0] ERR_ALL          = 2'h2;
  // status field codes
  localparam logic [2:0] STAT_BLANK       = 3'h0;
  localparam logic [2:0] STAT_ACCEL       = 3'h1;
  localparam logic [2:0] STAT_RPM         = 3'h2;
  localparam logic [2:0] STAT_SPEED       = 3'h3;
  localparam logic [2:0] STAT_STEER       = 3'h4;
  localparam logic [2:0] STAT_CURRENT     = 3'h5;
  // analogue setup codes
  localparam logic [1:0] ANA_ACCEL8       = 2'h0;
  localparam logic [1:0] ANA_ACCEL9       = 2'h1;
  localparam logic [1:0] ANA_WIGWAG       = 2'h2;
  // single/dual codes
  localparam logic [1:0] DUAL_SINGLE      = 2'h0;
  localparam logic [1:0] DUAL_LEFT        = 2'h1;
  localparam logic [1:0] DUAL_RIGHT       = 2'h2;
  // indicator codes, node numbers
  localparam logic       IND_FAULT        = 1'h0;
  localparam logic       IND_BRAKE_LIGHT  = 1'h1;
  localparam logic [3:0] NODE_MASTER      = 4'h0;
  localparam logic [3:0] NODE_FIRST_SLAVE = 4'h1;
  // fixed neutral ramp for tiller codes 1 and 2
  localparam int         FIXED_RAMP_MS    = 500;
  localparam int         CLK_MHZ          = 125;
  localparam int         FIXED_RAMP_CYC   = FIXED_RAMP_MS * 1000 * CLK_MHZ;

  // switch inputs, 1 = closed
  typedef struct packed {
    logic fwd;
    logic rev;
    logic pin3;
    logic pin4;
    logic pin7;
    logic footbrake;
  } tio_switch_t;

  // static configuration
  typedef struct packed {
    logic       pin7_function_select;
    logic [1:0] steer_trigger_select;
    logic [1:0] truck_type;
    logic [1:0] tiller_brake_function;
    logic [1:0] error_display_filter;
    logic [2:0] status_field_select;
    logic       temp_sensor_type;
    logic [1:0] analogue_setup;
    logic [1:0] single_dual_select;
    logic       indicator_output_select;
    logic       torque_mode;
    logic [3:0] node_number;
    logic       contactor_sharing_enable;
    logic [3:0] highest_sharing_node;
  } tio_cfg_t;

  // tiller braking states
  typedef enum logic [1:0] {
    TS_IDLE  = 2'b00,
    TS_BRAKE = 2'b01,
    TS_HOLD  = 2'b10,
    TS_PARK  = 2'b11
  } tio_till_t;
endpackage : tio_pkg

// ===== tio_top.sv
// traction io function configuration logic
`timescale 1ns/1ps
// Behaviour
// R1: code 0: speed limit three when open
// R2: code 1: limit when closed, show parked
// R3: steer contactor held for delay after stop
// R4: steer trigger foot, direction, or seat
// R5: code 3 adds motor speed above zero
// R6: truck type maps pins three and four
// R7: type 2 drives tiller-open with pin seven
// R8: tiller 0: hold end delay, then brake
// R9: tiller 1: fixed ramp, brake at stop
// R10: tiller 2: brake on opening, fixed ramp
// R11: type 2 with pin seven: no brake
// R12: error filter hard, main, warning levels
// R13: status field select; speed blank if zero
// R14: analogue eight/nine mapping and wig-wag
// R15: shared input: temperature or steering side
// R16: dual motor only in torque mode
// R17: indicator: brake light or fault lamp
// R18: node zero master, others slaves
// R19: slave takes master battery indication
// R20: master opens contactor on error/timeout
// R21: safe-mode warning when contactor opens
// R22: sharing slaves one to highest node
// R23: configuration static, switches synchronised
module tio_top #(
  parameter int unsigned DELAY_W = 24,
  parameter int unsigned DATA_W  = 16
) (
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire tio_pkg::tio_cfg_t  cfg,
  input  wire tio_pkg::tio_switch_t sw,
  input  wire logic [DELAY_W-1:0] steer_delay,
  input  wire logic [DELAY_W-1:0] end_delay,
  input  wire logic [DELAY_W-1:0] neutral_ramp,
  input  wire logic               motor_moving,
  input  wire logic               driving,
  input  wire logic               fault_active,
  input  wire logic               err_hard,
  input  wire logic               err_main,
  input  wire logic               err_warn,
  input  wire logic [DATA_W-1:0]  accel_pct,
  input  wire logic [DATA_W-1:0]  motor_rpm,
  input  wire logic [DATA_W-1:0]  vehicle_speed,
  input  wire logic [DATA_W-1:0]  max_vehicle_speed,
  input  wire logic [DATA_W-1:0]  steer_angle,
  input  wire logic [DATA_W-1:0]  motor_current,
  input  wire logic [7:0]         own_bdi,
  input  wire logic [7:0]         master_bdi,
  input  wire logic [15:0]        slave_hard_err,
  input  wire logic [15:0]        slave_timeout,
  output logic                    speed_limit3,
  output logic                    parked_icon,
  output logic                    steer_contactor,
  output logic                    footswitch,
  output logic                    seat_switch,
  output logic                    belly_button,
  output logic                    drive_permit,
  output logic                    neutral_braking,
  output logic                    fixed_ramp,
  output logic                    brake_apply,
  output logic                    pulsing,
  output logic                    error_shown,
  output logic [DATA_W-1:0]       status_value,
  output logic                    accel_on_pin9,
  output logic                    wigwag_mode,
  output logic                    temp_cutback_en,
  output logic                    temp_sensor_alt,
  output logic                    steer_feedback_en,
  output logic                    right_unit,
  output logic                    dual_config_error,
  output logic                    indicator_out,
  output logic                    is_master,
  output logic [7:0]              battery_discharge_indication,
  output logic                    line_contactor,
  output logic                    safe_mode_msg,
  output logic [15:0]             sharing_nodes
);
  localparam logic [DELAY_W-1:0] DZERO = '0;
  localparam logic [DATA_W-1:0]  VZERO = '0;

  // switch synchroniser; stage one feeds stage two only
  tio_pkg::tio_switch_t sw_meta;
  tio_pkg::tio_switch_t sw_s;
  tio_pkg::tio_cfg_t    cfg_q;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sw_meta <= '0;
      sw_s    <= '0;
      cfg_q   <= '0;
    end else begin
      sw_meta <= sw;       // see R23
      sw_s    <= sw_meta;
      cfg_q   <= cfg;      // see R23
    end
  end

  // pin role decoding
  logic walkie;
  logic tiller_closed;
  logic in_foot;
  logic in_seat;
  logic pin7_closed;
  logic open_drive_ok;
  assign walkie        = (cfg_q.truck_type != tio_pkg::TRUCK_RIDE);        // see R6
  assign in_foot       = !walkie && sw_s.pin3;                              // see R6
  assign in_seat       = !walkie && sw_s.pin4;
  assign tiller_closed = walkie && sw_s.pin4;
  assign pin7_closed   = sw_s.pin7;
  assign open_drive_ok = (cfg_q.truck_type == tio_pkg::TRUCK_WALK_OPEN) && pin7_closed; // see R7

  // steer trigger and run-on timer
  logic                steer_trig;
  logic [DELAY_W-1:0]  steer_cnt;
  logic [DELAY_W-1:0]  next_steer_cnt;
  logic                next_steer_on;
  always_comb begin
    case (cfg_q.steer_trigger_select)                                        // see R4
      tio_pkg::STEER_FOOT:       steer_trig = in_foot;
      tio_pkg::STEER_DIR:        steer_trig = sw_s.fwd || sw_s.rev;
      tio_pkg::STEER_SEAT:       steer_trig = in_seat;
      tio_pkg::STEER_FOOT_SPEED: steer_trig = in_foot || motor_moving;      // see R5
      default:                   steer_trig = 1'b0;
    endcase
    next_steer_cnt = steer_cnt;
    next_steer_on  = 1'b0;
    // trigger or driving reloads; countdown only starts once drive stops
    if (steer_trig || driving) begin
      next_steer_cnt = steer_delay;                                          // see R3
      next_steer_on  = 1'b1;
    end else if (steer_cnt != DZERO) begin
      next_steer_cnt = steer_cnt - 1'b1;                                     // see R3
      next_steer_on  = 1'b1;
    end
  end

  // tiller braking sequence
  tio_pkg::tio_till_t  till_st;
  tio_pkg::tio_till_t  next_till_st;
  logic [DELAY_W-1:0]  till_cnt;
  logic [DELAY_W-1:0]  next_till_cnt;
  logic                next_neutral;
  logic                next_brake;
  logic                next_pulsing;
  logic                tiller_open;
  logic                brake_inhibit;
  assign tiller_open   = walkie && !tiller_closed && !open_drive_ok;
  assign brake_inhibit = (cfg_q.truck_type == tio_pkg::TRUCK_WALK_OPEN) && pin7_closed; // see R11
  always_comb begin
    next_till_st = till_st;
    next_till_cnt = till_cnt;
    next_neutral = 1'b0;
    next_brake   = 1'b0;
    next_pulsing = 1'b1;
    case (till_st)
      tio_pkg::TS_IDLE: begin
        if (tiller_open) begin
          next_till_st = tio_pkg::TS_BRAKE;
        end
      end
      tio_pkg::TS_BRAKE: begin
        next_neutral = 1'b1;                                                 // see R8
        next_brake = (cfg_q.tiller_brake_function == tio_pkg::TILL_OPEN_BRAKE); // see R10
        if (!motor_moving) begin
          next_till_st  = tio_pkg::TS_HOLD;
          next_till_cnt = end_delay;
        end
      end
      tio_pkg::TS_HOLD: begin
        // code 0 holds electrically; codes 1 and 2 brake at once
        next_brake = (cfg_q.tiller_brake_function != tio_pkg::TILL_HOLD);    // see R9
        if (till_cnt == DZERO) begin
          next_till_st = tio_pkg::TS_PARK;
        end else begin
          next_till_cnt = till_cnt - 1'b1;                                   // see R8
        end
      end
      tio_pkg::TS_PARK: begin
        next_brake   = 1'b1;
        next_pulsing = 1'b0;                                                 // see R9
      end
      default: next_till_st = tio_pkg::TS_IDLE;
    endcase
    if (!tiller_open) begin
      next_till_st = tio_pkg::TS_IDLE;
    end
    if (brake_inhibit) begin
      next_brake = 1'b0;                                                     // see R11
    end
  end

  // derived configuration outputs
  logic              next_err;
  logic [DATA_W-1:0] next_status;
  always_comb begin
    case (cfg_q.error_display_filter)                                        // see R12
      tio_pkg::ERR_HARD: next_err = err_hard;
      tio_pkg::ERR_MAIN: next_err = err_hard || err_main;
      tio_pkg::ERR_ALL:  next_err = err_hard || err_main || err_warn;
      default:           next_err = err_hard;
    endcase
    case (cfg_q.status_field_select)                                         // see R13
      tio_pkg::STAT_ACCEL:   next_status = accel_pct;
      tio_pkg::STAT_RPM:     next_status = motor_rpm;
      tio_pkg::STAT_SPEED:
        next_status = (max_vehicle_speed == VZERO) ? VZERO : vehicle_speed;  // see R13
      tio_pkg::STAT_STEER:   next_status = steer_angle;
      tio_pkg::STAT_CURRENT: next_status = motor_current;
      default:               next_status = VZERO;
    endcase
  end

  // shared contactor supervision for the master
  logic        master;
  logic [15:0] share_mask;
  logic        share_fault;
  assign master = (cfg_q.node_number == tio_pkg::NODE_MASTER);               // see R18
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_share
      // consecutive slaves from one up to the highest sharing node
      assign share_mask[gi] = master && cfg_q.contactor_sharing_enable &&
        (4'(gi) >= tio_pkg::NODE_FIRST_SLAVE) &&
        (4'(gi) <= cfg_q.highest_sharing_node);                              // see R22
    end
  endgenerate
  assign share_fault = |(share_mask & (slave_hard_err | slave_timeout));      // see R20
  logic next_lc;
  assign next_lc = master ? !(err_hard || share_fault) : !err_hard;

  // output registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      steer_cnt <= '0;
      till_st <= tio_pkg::TS_IDLE;
      till_cnt <= '0;
      speed_limit3 <= 1'b0;
      parked_icon <= 1'b0;
      steer_contactor <= 1'b0;
      footswitch <= 1'b0;
      seat_switch <= 1'b0;
      belly_button <= 1'b0;
      drive_permit <= 1'b0;
      neutral_braking <= 1'b0;
      fixed_ramp <= 1'b0;
      brake_apply <= 1'b1;
      pulsing <= 1'b0;
      error_shown <= 1'b0;
      status_value <= '0;
      accel_on_pin9 <= 1'b0;
      wigwag_mode <= 1'b0;
      temp_cutback_en <= 1'b0;
      temp_sensor_alt <= 1'b0;
      steer_feedback_en <= 1'b0;
      right_unit <= 1'b0;
      dual_config_error <= 1'b0;
      indicator_out <= 1'b0;
      is_master <= 1'b0;
      battery_discharge_indication <= '0;
      line_contactor <= 1'b0;
      safe_mode_msg <= 1'b0;
      sharing_nodes <= '0;
    end else begin
      steer_cnt <= next_steer_cnt;
      till_st <= next_till_st;
      till_cnt <= next_till_cnt;
      // pin seven: open-limits for code 0, closed-limits and parked for code 1
      speed_limit3 <= (cfg_q.pin7_function_select == tio_pkg::PIN7_SPEED_LIMIT)
        ? !pin7_closed : pin7_closed;                                        // see R1
      parked_icon <= (cfg_q.pin7_function_select == tio_pkg::PIN7_HANDBRAKE)
        && pin7_closed;                                                      // see R2
      steer_contactor <= next_steer_on;
      footswitch <= in_foot;
      seat_switch <= in_seat;
      belly_button <= walkie && sw_s.pin3;                                   // see R6
      drive_permit <= walkie ? (tiller_closed || open_drive_ok) : in_seat;   // see R7
      neutral_braking <= next_neutral;
      fixed_ramp <= walkie && (cfg_q.tiller_brake_function != tio_pkg::TILL_HOLD); // see R9
      brake_apply <= next_brake;
      pulsing <= next_pulsing;
      error_shown <= next_err;
      status_value <= next_status;
      accel_on_pin9 <= (cfg_q.analogue_setup != tio_pkg::ANA_ACCEL8);         // see R14
      wigwag_mode <= (cfg_q.analogue_setup == tio_pkg::ANA_WIGWAG);          // see R14
      temp_cutback_en <= (cfg_q.single_dual_select == tio_pkg::DUAL_SINGLE); // see R15
      temp_sensor_alt <= cfg_q.temp_sensor_type;
      steer_feedback_en <= (cfg_q.single_dual_select != tio_pkg::DUAL_SINGLE)
        && cfg_q.torque_mode;                                                // see R16
      right_unit <= (cfg_q.single_dual_select == tio_pkg::DUAL_RIGHT);       // see R15
      dual_config_error <= (cfg_q.single_dual_select != tio_pkg::DUAL_SINGLE)
        && !cfg_q.torque_mode;                                               // see R16
      indicator_out <= (cfg_q.indicator_output_select == tio_pkg::IND_BRAKE_LIGHT)
        ? sw_s.footbrake : fault_active;                                     // see R17
      is_master <= master;
      battery_discharge_indication <= master ? own_bdi : master_bdi;          // see R19
      line_contactor <= next_lc;
      // one pulse on each opening of the contactor, sent only by a master with sharing enabled
      safe_mode_msg <= master && line_contactor && !next_lc &&
        cfg_q.contactor_sharing_enable;                                      // see R21
      sharing_nodes <= share_mask;
    end
  end
endmodule : tio_top

// ===== tio_top_assertions.sv
// port-level checks for the traction io function block
`timescale 1ns/1ps
module tio_top_assertions #(
  parameter int unsigned DATA_W = 16
) (
  input wire logic                 ref_clk,
  input wire logic                 nrst,
  input wire tio_pkg::tio_cfg_t    cfg,
  input wire tio_pkg::tio_switch_t sw,
  input wire logic                 err_hard,
  input wire logic [15:0]          slave_hard_err,
  input wire logic                 speed_limit3,
  input wire logic                 parked_icon,
  input wire logic                 steer_contactor,
  input wire logic                 error_shown,
  input wire logic [DATA_W-1:0]    status_value,
  input wire logic                 indicator_out,
  input wire logic                 is_master,
  input wire logic                 line_contactor,
  input wire logic                 safe_mode_msg
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // switches pass two sync stages and a register, so five steady samples
  sequence s_pin7_held(logic sel);
    (cfg.pin7_function_select == sel && $stable(sw.pin7)) [*5];
  endsequence
  sequence s_share_fault;
    (cfg.node_number == 4'h0 && cfg.contactor_sharing_enable &&
     cfg.highest_sharing_node != 4'h0 && slave_hard_err[1]) [*4];
  endsequence

  property p_limit_open;
    s_pin7_held(1'b0) |-> speed_limit3 == !sw.pin7;
  endproperty
  a_limit_open: assert property (p_limit_open) else $error("limit open");
  property p_park;
    s_pin7_held(1'b1) |-> {speed_limit3, parked_icon} == {2{sw.pin7}};
  endproperty
  a_park: assert property (p_park) else $error("park icon");
  property p_steer_foot;
    (cfg.truck_type == 2'h0 && cfg.steer_trigger_select == 2'h0 && sw.pin3) [*5]
      |-> steer_contactor;
  endproperty
  a_steer_foot: assert property (p_steer_foot) else $error("steer foot");
  property p_err_hard;
    (cfg.error_display_filter == 2'h0 && $stable(err_hard)) [*4] |-> error_shown == err_hard;
  endproperty
  a_err_hard: assert property (p_err_hard) else $error("error filter");
  property p_blank;
    (cfg.status_field_select == 3'h0) [*4] |-> status_value == '0;
  endproperty
  a_blank: assert property (p_blank) else $error("status blank");
  property p_brake_light;
    (cfg.indicator_output_select && $stable(sw.footbrake)) [*5]
      |-> indicator_out == sw.footbrake;
  endproperty
  a_brake_light: assert property (p_brake_light) else $error("brake light");
  property p_share_err;
    s_share_fault |-> !line_contactor;
  endproperty
  a_share_err: assert property (p_share_err) else $error("shared contactor");
  // the warning is a single pulse and only a master sends it
  property p_safe_pulse;
    safe_mode_msg |-> is_master ##1 !safe_mode_msg;
  endproperty
  a_safe_pulse: assert property (p_safe_pulse) else $error("safe pulse");
endmodule : tio_top_assertions

// ===== tio_vehicle_model.sv
// vehicle side: switch contacts and peer controllers on the shared contactor
`timescale 1ns/1ps
module tio_vehicle_model (
  input  wire logic                 ref_clk,
  input  wire tio_pkg::tio_switch_t req_sw,
  input  wire logic [15:0]          peer_err,
  input  wire logic [15:0]          peer_mute,
  output tio_pkg::tio_switch_t      sw,
  output logic [15:0]               slave_hard_err,
  output logic [15:0]               slave_timeout
);
  tio_pkg::tio_switch_t contact  = '0;
  logic [15:0]          hard_q   = 16'h0;
  logic [15:0]          mute_q   = 16'h0;

  // contacts settle one edge after the lever; no bounce, so timing stays exact
  always_ff @(posedge ref_clk) begin
    contact <= req_sw;
  end
  // peers report hard errors or miss the check; node 0 is the master itself
  always_ff @(posedge ref_clk) begin
    hard_q <= peer_err & 16'hFFFE;
    mute_q <= peer_mute & 16'hFFFE;
  end
  assign sw             = contact;
  assign slave_hard_err = hard_q;
  assign slave_timeout  = mute_q;
endmodule : tio_vehicle_model

// ===== tio_top_test.sv
// self-checking testbench for the traction io function block
`timescale 1ns/1ps
module tio_top_test;
  localparam int E = 30;
  logic                 ref_clk, nrst, motor_moving, driving, fault_active;
  logic                 err_hard, err_main, err_warn, walk, foot, seat, dual, lc;
  tio_pkg::tio_cfg_t    cfg, c;
  tio_pkg::tio_switch_t req_sw, sw, s;
  logic [23:0]          steer_delay, end_delay, neutral_ramp;
  logic [15:0]          accel_pct, motor_rpm, vehicle_speed, max_vehicle_speed, shr;
  logic [15:0]          steer_angle, motor_current, peer_err, peer_mute, sv [6];
  logic [15:0]          slave_hard_err, slave_timeout, status_value, sharing_nodes;
  logic [7:0]           own_bdi, master_bdi, battery_discharge_indication;
  logic [3:0]           trg;
  logic                 speed_limit3, parked_icon, steer_contactor, footswitch, seat_switch;
  logic                 belly_button, drive_permit, neutral_braking, fixed_ramp, brake_apply;
  logic                 pulsing, error_shown, accel_on_pin9, wigwag_mode, temp_cutback_en;
  logic                 temp_sensor_alt, steer_feedback_en, right_unit, dual_config_error;
  logic                 indicator_out, is_master, line_contactor, safe_mode_msg;
  int                   err_total = 0;
  int                   tests_run = 0;
  int                   n;

  tio_top #(.DELAY_W(24), .DATA_W(16)) u_tio_top (
    .ref_clk, .nrst, .cfg, .sw, .steer_delay, .end_delay, .neutral_ramp, .motor_moving,
    .driving, .fault_active, .err_hard, .err_main, .err_warn, .accel_pct, .motor_rpm,
    .vehicle_speed, .max_vehicle_speed, .steer_angle, .motor_current, .own_bdi,
    .master_bdi, .slave_hard_err, .slave_timeout, .speed_limit3, .parked_icon,
    .steer_contactor, .footswitch, .seat_switch, .belly_button, .drive_permit,
    .neutral_braking, .fixed_ramp, .brake_apply, .pulsing, .error_shown, .status_value,
    .accel_on_pin9, .wigwag_mode, .temp_cutback_en, .temp_sensor_alt, .steer_feedback_en,
    .right_unit, .dual_config_error, .indicator_out, .is_master,
    .battery_discharge_indication, .line_contactor, .safe_mode_msg, .sharing_nodes
  );
  tio_vehicle_model u_tio_vehicle_model (
    .ref_clk, .req_sw, .peer_err, .peer_mute, .sw, .slave_hard_err, .slave_timeout
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // outputs are read mid-cycle so the edge's updates have landed
  task automatic settle(input int k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // a hang is cut off far beyond the roughly 4200 cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    close_out();
  end

  initial begin
    {nrst, driving, fault_active, motor_moving, err_hard, err_main, err_warn} = '0;
    {cfg, req_sw, peer_err, peer_mute, own_bdi, master_bdi} = '0;
    {accel_pct, motor_rpm, vehicle_speed, max_vehicle_speed, steer_angle, motor_current} = '0;
    {steer_delay, end_delay, neutral_ramp} = {24'h2, 24'(E), 24'h64};
    void'($urandom(48));
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    // random settings held long enough for the short steer delay to run out
    for (int i = 0; i < 300; i++) begin
      @(posedge ref_clk);
      c = tio_pkg::tio_cfg_t'($bits(c)'($urandom));
      c.truck_type = 2'($urandom_range(2));
      c.error_display_filter = 2'($urandom_range(2));
      c.status_field_select = 3'($urandom_range(5));
      c.analogue_setup = 2'($urandom_range(2));
      c.single_dual_select = 2'($urandom_range(2));
      if ($urandom_range(1)) c.node_number = 4'h0;
      s = tio_pkg::tio_switch_t'(6'($urandom));
      cfg <= c;
      req_sw <= s;
      {fault_active, motor_moving, err_hard, err_main, err_warn} <= 5'($urandom);
      {accel_pct, motor_rpm} <= $urandom;
      {vehicle_speed, steer_angle} <= $urandom;
      {motor_current, own_bdi, master_bdi} <= $urandom;
      max_vehicle_speed <= $urandom_range(3) ? 16'($urandom) : 16'h0;
      peer_err <= $urandom_range(2) ? 16'h0 : 16'h1 << $urandom_range(3);
      peer_mute <= $urandom_range(2) ? 16'h0 : 16'h1 << $urandom_range(15);
      settle(12);
      walk = c.truck_type != 2'h0;
      foot = !walk & s.pin3;
      seat = !walk & s.pin4;
      dual = c.single_dual_select != 2'h0;
      trg = {foot | motor_moving, seat, s.fwd | s.rev, foot};
      sv = '{16'h0, accel_pct, motor_rpm, max_vehicle_speed == 16'h0 ? 16'h0 : vehicle_speed,
             steer_angle, motor_current};
      shr = (c.contactor_sharing_enable && c.node_number == 4'h0) ?
            16'((17'h2 << c.highest_sharing_node) - 17'h2) : 16'h0;
      lc = !(err_hard | (|(shr & (peer_err | peer_mute))));
      chk(speed_limit3, c.pin7_function_select ? s.pin7 : !s.pin7);
      chk(parked_icon, c.pin7_function_select & s.pin7);
      chk(steer_contactor, trg[c.steer_trigger_select]);
      chk({footswitch, seat_switch, belly_button}, {foot, seat, walk & s.pin3});
      if (walk) chk(drive_permit, s.pin4 | (c.truck_type == 2'h2 & s.pin7));
      if (c.truck_type == 2'h2 && s.pin7) chk(brake_apply, 1'b0);
      chk(error_shown, err_hard | (c.error_display_filter != 2'h0 & err_main) |
          (c.error_display_filter == 2'h2 & err_warn));
      chk(status_value, sv[c.status_field_select]);
      chk({accel_on_pin9, wigwag_mode}, {c.analogue_setup != 2'h0, c.analogue_setup == 2'h2});
      chk({temp_sensor_alt, right_unit}, {c.temp_sensor_type, c.single_dual_select == 2'h2});
      chk({temp_cutback_en, steer_feedback_en, dual_config_error},
          {!dual, dual & c.torque_mode, dual & !c.torque_mode});
      chk(indicator_out, c.indicator_output_select ? s.footbrake : fault_active);
      chk(is_master, c.node_number == 4'h0);
      chk(battery_discharge_indication, c.node_number == 4'h0 ? own_bdi : master_bdi);
      if (c.contactor_sharing_enable && c.node_number == 4'h0) chk(sharing_nodes, shr);
      chk(line_contactor, lc);
    end
    // steer contactor outlasts the footswitch by the programmed delay
    @(posedge ref_clk);
    c = '0;
    s = '0;
    s.pin3 = 1'b1;
    {cfg, req_sw, peer_err, peer_mute} <= {c, s, 32'h0};
    {err_hard, err_main, err_warn, fault_active, motor_moving} <= 5'h0;
    steer_delay <= 24'h14;
    settle(10);
    chk(steer_contactor, 1'b1);
    @(posedge ref_clk);
    req_sw <= '0;
    n = 0;
    while (steer_contactor !== 1'b0 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    chk(n >= 21 && n <= 28, 1'b1);
    // each tiller code: open the tiller while moving, then stop the motor
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      c = '0;
      c.truck_type = 2'h1;
      c.tiller_brake_function = 2'(k);
      s = '0;
      s.pin4 = 1'b1;
      cfg <= c;
      req_sw <= s;
      motor_moving <= 1'b1;
      settle(10);
      @(posedge ref_clk);
      req_sw <= '0;
      settle(6);
      chk({neutral_braking, brake_apply, fixed_ramp}, {1'b1, k == 2, k != 0});
      @(posedge ref_clk);
      motor_moving <= 1'b0;
      n = 0;
      while (brake_apply !== 1'b1 && n < 200) begin
        @(negedge ref_clk);
        n++;
      end
      chk(k == 0 ? (n >= E && n <= E + 4) : (n <= 3), 1'b1);
      settle(E + 10);
      chk(pulsing, 1'b0);
    end
    // a sharing peer stops answering: contactor opens, one warning goes out
    @(posedge ref_clk);
    c = '0;
    c.contactor_sharing_enable = 1'b1;
    c.highest_sharing_node = 4'h3;
    cfg <= c;
    settle(8);
    chk(line_contactor, 1'b1);
    @(posedge ref_clk);
    peer_mute <= 16'h0004;
    n = 0;
    repeat (10) begin
      @(negedge ref_clk);
      n += int'(safe_mode_msg === 1'b1);
    end
    chk(32'(n), 32'h1);
    chk(line_contactor, 1'b0);
    close_out();
  end
endmodule : tio_top_test

bind tio_top tio_top_assertions #(.DATA_W(DATA_W)) u_tio_top_assertions (
  .ref_clk, .nrst, .cfg, .sw, .err_hard, .slave_hard_err, .speed_limit3, .parked_icon,
  .steer_contactor, .error_shown, .status_value, .indicator_out, .is_master,
  .line_contactor, .safe_mode_msg
);
